//--- src/sdpbr_pkg.sv
package sdpbr_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned PAR_W = 8;
  localparam int unsigned WORD_W = 72;
  localparam int unsigned HALF_W = 36;
  localparam int unsigned DEPTH = 512;

  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;

  localparam int unsigned CTRL_WMODE_LSB = 0;
  localparam int unsigned CTRL_OREG_ON_BIT = 2;
  localparam int unsigned CTRL_ORDER_LSB = 3;
  localparam int unsigned CTRL_HALF_BIT = 5;
  localparam int unsigned CTRL_W = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  localparam int unsigned STAT_COLL_BIT = 0;
  localparam int unsigned STAT_SLEEP_BIT = 1;
  localparam int unsigned STAT_OREG_ON_BIT = 2;

  localparam logic [71:0] LATCH_SRVAL = 72'h00_0000_0000_0000_0000;
  localparam logic [71:0] OREG_SRVAL = 72'h00_0000_0000_0000_0000;
  localparam logic [8:0] ADDR_RESET = 9'h000;
  localparam logic [1:0] SEL_RESET = 2'h0;

  typedef enum logic [1:0] {
    SDPBR_WRITE_FIRST,
    SDPBR_READ_FIRST,
    SDPBR_NO_CHANGE
  } sdpbr_wmode_e;

  typedef enum logic [1:0] {
    SDPBR_ORDER_NONE,
    SDPBR_ORDER_FIRST,
    SDPBR_ORDER_MIDDLE,
    SDPBR_ORDER_LAST
  } sdpbr_order_e;

endpackage

//--- src/sdpbr_block.sv
// Contract
// - Split mode word is 36 bits for half block and 72 for full.
// - First port only reads, second only writes, both in the same cycle.
// - Same read and write location at once counts as a collision.
// - Write modes: show old data, show new data, or keep output.
// - Read and write sides each have own clock, address and enable; here both share clk_i, each side with its own clock enable.
// - Register reset sets output registers synchronously to the read clock.
// - Latch reset sets output latches synchronously, apart from register reset.
// - Output register loads only while its clock enable is high.
// - Address hold low keeps the previously captured address.
// - Power-saving input high puts the block into power saving.
// - Cascade data flows upward, at every width, over many blocks.
// - Lower and upper halves cascade into the block above independently.
// - Write source select picks cascade input or direct data input.
// - Register source select picks memory output or cascade input.
// - Final select picks own output or cascade input for both outputs.
// - Register and final selects are captured, each under its own enable.
// - Cascade and ordinary data connections are usable together.
// - Settings fix cascade position and switch the output register.
// - Read reaches latches one edge after address; register adds one.
// - Read-before-write puts previous contents on the latches.
// - Two different writes to one location leave it undefined.
// - Collision read is defined only on common clock with read-before-write.
`timescale 1ns/1ns
`default_nettype none

module sdpbr_block (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic read_clock_en_i,
  input wire logic read_port_enable_i,
  input wire logic [8:0] read_address_i,
  input wire logic read_address_hold_n_i,
  input wire logic out_reg_clock_enable_i,
  input wire logic out_reg_reset_i,
  input wire logic out_latch_reset_i,
  output logic [63:0] read_data_o,
  output logic [7:0] read_parity_out_o,
  input wire logic write_clock_en_i,
  input wire logic write_port_enable_i,
  input wire logic [8:0] write_address_i,
  input wire logic write_address_hold_n_i,
  input wire logic [63:0] write_data_i,
  input wire logic [7:0] write_parity_in_i,
  input wire logic sleep_i,
  input wire logic [63:0] chain_data_in_i,
  input wire logic [7:0] chain_parity_in_i,
  output logic [63:0] chain_data_out_o,
  output logic [7:0] chain_parity_out_o,
  input wire logic [1:0] write_source_select_i,
  input wire logic [1:0] register_source_select_i,
  input wire logic register_source_select_en_i,
  input wire logic [1:0] final_output_select_i,
  input wire logic final_output_select_en_i
);

  // Each 36-bit half is {4 parity bits, 32 data bits}; half 0 sits low.
  function automatic logic [71:0] pack_word(input logic [63:0] d, input logic [7:0] p);
    pack_word = {p[7:4], d[63:32], p[3:0], d[31:0]};
  endfunction

  function automatic logic [63:0] word_data(input logic [71:0] w);
    word_data = {w[67:36], w[31:0]};
  endfunction

  function automatic logic [7:0] word_parity(input logic [71:0] w);
    word_parity = {w[71:68], w[35:32]};
  endfunction

  // Per half, select bit set picks b, clear picks a.
  function automatic logic [71:0] half_mux(input logic [1:0] sel, input logic [71:0] a, input logic [71:0] b);
    half_mux = {sel[1] ? b[71:36] : a[71:36], sel[0] ? b[35:0] : a[35:0]};
  endfunction

  logic [71:0] mem [sdpbr_pkg::DEPTH];

  logic [5:0] ctrl_q, ctrl_d;
  logic coll_q, coll_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic [8:0] rd_addr_q, rd_addr_d;
  logic [8:0] wr_addr_q, wr_addr_d;
  logic [71:0] latch_q, latch_d;
  logic [71:0] oreg_q, oreg_d;
  logic [1:0] regsel_q, regsel_d;
  logic [1:0] finsel_q, finsel_d;

  sdpbr_pkg::sdpbr_wmode_e wmode;
  sdpbr_pkg::sdpbr_order_e order;
  logic oreg_on, half_mode;
  logic [8:0] rd_addr_eff, wr_addr_eff;
  logic rd_go, wr_go, coll;
  logic [71:0] chain_word, wr_word, rd_word, final_word, half_mask;
  logic apb_setup, apb_write;

  assign wmode = sdpbr_pkg::sdpbr_wmode_e'(ctrl_q[sdpbr_pkg::CTRL_WMODE_LSB +: 2]);
  assign order = sdpbr_pkg::sdpbr_order_e'(ctrl_q[sdpbr_pkg::CTRL_ORDER_LSB +: 2]);
  assign oreg_on = ctrl_q[sdpbr_pkg::CTRL_OREG_ON_BIT];
  assign half_mode = ctrl_q[sdpbr_pkg::CTRL_HALF_BIT];
  // Half mode keeps only the low 36-bit half of the word.
  assign half_mask = half_mode ? {36'h0_0000_0000, 36'hf_ffff_ffff} : {72{1'b1}};

  // APB slave: read data and error are prepared in the setup cycle, so the access phase ends at once.
  assign apb_setup = psel_i && !penable_i;
  assign apb_write = psel_i && penable_i && pwrite_i;
  assign pready_o = psel_i && penable_i;
  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q && psel_i && penable_i;

  always_comb begin
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    if (apb_setup) begin
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (paddr_i == sdpbr_pkg::OFS_CTRL) begin
        prdata_d[sdpbr_pkg::CTRL_W-1:0] = ctrl_q;
      end else if (paddr_i == sdpbr_pkg::OFS_STATUS) begin
        prdata_d[sdpbr_pkg::STAT_COLL_BIT] = coll_q;
        prdata_d[sdpbr_pkg::STAT_SLEEP_BIT] = sleep_i;
        prdata_d[sdpbr_pkg::STAT_OREG_ON_BIT] = oreg_on;
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Configuration and the sticky collision flag; a new collision beats a clear in the same cycle.
  always_comb begin
    ctrl_d = ctrl_q;
    coll_d = coll_q;
    if (apb_write && paddr_i == sdpbr_pkg::OFS_CTRL) begin
      ctrl_d = pwdata_i[sdpbr_pkg::CTRL_W-1:0];
    end
    if (apb_write && paddr_i == sdpbr_pkg::OFS_STATUS && pwdata_i[sdpbr_pkg::STAT_COLL_BIT]) begin
      coll_d = 1'b0;
    end
    if (coll) begin
      coll_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= sdpbr_pkg::CTRL_RESET;
      coll_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      coll_q <= coll_d;
    end
  end

  // The bottom block of a chain has nothing below it, so its cascade input reads as zero.
  assign chain_word = (order == sdpbr_pkg::SDPBR_ORDER_FIRST) ? 72'h0 :
                      pack_word(chain_data_in_i, chain_parity_in_i);

  // Each side has its own clock enable, address, address hold and port enable.
  assign rd_addr_eff = read_address_hold_n_i ? read_address_i : rd_addr_q;
  assign wr_addr_eff = write_address_hold_n_i ? write_address_i : wr_addr_q;
  assign rd_go = read_clock_en_i && read_port_enable_i && !sleep_i;
  assign wr_go = write_clock_en_i && write_port_enable_i && !sleep_i;
  assign coll = rd_go && wr_go && (rd_addr_eff == wr_addr_eff);
  assign rd_word = mem[rd_addr_eff];

  // Per half, stored data comes from the cascade input or the direct data input.
  assign wr_word = half_mux(write_source_select_i, pack_word(write_data_i, write_parity_in_i),
                            chain_word);

  always_comb begin
    rd_addr_d = rd_addr_q;
    wr_addr_d = wr_addr_q;
    if (read_clock_en_i && read_address_hold_n_i) begin
      rd_addr_d = read_address_i;
    end
    if (write_clock_en_i && write_address_hold_n_i) begin
      wr_addr_d = write_address_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_addr_q <= sdpbr_pkg::ADDR_RESET;
      wr_addr_q <= sdpbr_pkg::ADDR_RESET;
    end else begin
      rd_addr_q <= rd_addr_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // A single write port means two writes can never meet at one location here.
  always_ff @(posedge clk_i) begin
    if (wr_go) begin
      mem[wr_addr_eff] <= (wr_word & half_mask) | (mem[wr_addr_eff] & ~half_mask);
    end
  end

  // Output latches: one edge after the address is taken, with the write mode settling collisions.
  always_comb begin
    latch_d = latch_q;
    if (rd_go) begin
      if (out_latch_reset_i) begin
        latch_d = sdpbr_pkg::LATCH_SRVAL;
      end else if (!coll) begin
        latch_d = rd_word & half_mask;
      end else begin
        // Both sides share clk_i, so every mode gives a defined result here.
        unique case (wmode)
          sdpbr_pkg::SDPBR_READ_FIRST: latch_d = rd_word & half_mask;
          sdpbr_pkg::SDPBR_NO_CHANGE: latch_d = latch_q;
          default: latch_d = wr_word & half_mask;
        endcase
      end
    end
  end

  // Output register and the two captured selects run on the read-side enable.
  always_comb begin
    oreg_d = oreg_q;
    regsel_d = regsel_q;
    finsel_d = finsel_q;
    if (read_clock_en_i) begin
      if (out_reg_reset_i) begin
        oreg_d = sdpbr_pkg::OREG_SRVAL;
      end else if (out_reg_clock_enable_i) begin
        oreg_d = half_mux(regsel_q, latch_q, chain_word) & half_mask;
      end
      if (register_source_select_en_i) begin
        regsel_d = register_source_select_i;
      end
      if (final_output_select_en_i) begin
        finsel_d = final_output_select_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_q <= sdpbr_pkg::LATCH_SRVAL;
      oreg_q <= sdpbr_pkg::OREG_SRVAL;
      regsel_q <= sdpbr_pkg::SEL_RESET;
      finsel_q <= sdpbr_pkg::SEL_RESET;
    end else begin
      latch_q <= latch_d;
      oreg_q <= oreg_d;
      regsel_q <= regsel_d;
      finsel_q <= finsel_d;
    end
  end

  // The final mux feeds both the data output and the cascade output toward the block above.
  assign final_word = half_mux(finsel_q, oreg_on ? oreg_q : latch_q, chain_word) & half_mask;
  assign read_data_o = word_data(final_word);
  assign read_parity_out_o = word_parity(final_word);
  assign chain_data_out_o = word_data(final_word);
  assign chain_parity_out_o = word_parity(final_word);

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic [71:0] masked_rd, masked_wr;
  assign masked_rd = rd_word & half_mask;
  assign masked_wr = wr_word & half_mask;

  sequence s_read_issue;
    rd_go && !out_latch_reset_i && !coll;
  endsequence

  sequence s_oreg_load;
    read_clock_en_i && out_reg_clock_enable_i && !out_reg_reset_i && regsel_q == 2'b00;
  endsequence

  sequence s_final_load;
    read_clock_en_i && final_output_select_en_i;
  endsequence

  chk_latch_read_data: assert property (s_read_issue |=> latch_q == $past(masked_rd))
    else $error("latch did not take memory data one edge after the read");
  chk_read_pipe_depth: assert property (s_read_issue ##1 s_oreg_load |=> oreg_q == $past(latch_q, 1))
    else $error("output register missed the latched read data");
  chk_latch_reset_value: assert property (rd_go && out_latch_reset_i |=> latch_q == sdpbr_pkg::LATCH_SRVAL)
    else $error("latch reset did not load the set/reset value");
  chk_oreg_reset_value: assert property (read_clock_en_i && out_reg_reset_i |=> oreg_q == sdpbr_pkg::OREG_SRVAL)
    else $error("register reset did not load the set/reset value");
  chk_oreg_hold_value: assert property (!(read_clock_en_i && (out_reg_clock_enable_i || out_reg_reset_i)) |=> $stable(oreg_q))
    else $error("output register changed without its clock enable");
  chk_addr_hold_old: assert property (read_clock_en_i && !read_address_hold_n_i |=> rd_addr_q == $past(rd_addr_q))
    else $error("read address changed while held");
  chk_collision_flag: assert property (coll |=> coll_q)
    else $error("collision flag not set after a collision");
  chk_write_first_data: assert property (coll && !out_latch_reset_i && wmode == sdpbr_pkg::SDPBR_WRITE_FIRST |=> latch_q == $past(masked_wr))
    else $error("write-first collision did not show the new data");
  chk_read_first_data: assert property (coll && !out_latch_reset_i && wmode == sdpbr_pkg::SDPBR_READ_FIRST |=> latch_q == $past(masked_rd))
    else $error("read-first collision did not show the old data");
  chk_no_change_hold: assert property (coll && !out_latch_reset_i && wmode == sdpbr_pkg::SDPBR_NO_CHANGE |=> $stable(latch_q))
    else $error("no-change collision altered the latch");
  chk_sleep_quiet_latch: assert property (sleep_i |=> $stable(latch_q))
    else $error("latch changed while in power saving");
  chk_final_sel_load: assert property (s_final_load |=> finsel_q == $past(final_output_select_i))
    else $error("final select not captured under its enable");
  chk_cascade_pass: assert property (finsel_q == 2'b11 |-> final_word == (chain_word & half_mask))
    else $error("final mux did not pass the cascade input");

  // Upper half that the output register takes from below, and a software clear of the collision flag.
  logic [35:0] chain_hi;
  assign chain_hi = chain_word[71:36] & half_mask[71:36];
  logic coll_clr;
  assign coll_clr = apb_write && paddr_i == sdpbr_pkg::OFS_STATUS && pwdata_i[sdpbr_pkg::STAT_COLL_BIT];

  sequence s_reg_sel_load;
    read_clock_en_i && register_source_select_en_i;
  endsequence

  sequence s_oreg_chain_load;
    read_clock_en_i && out_reg_clock_enable_i && !out_reg_reset_i && regsel_q[1];
  endsequence

  sequence s_write_issue;
    wr_go;
  endsequence

  sequence s_read_back;
    rd_go && !out_latch_reset_i && !coll;
  endsequence

  chk_write_read_back: assert property (s_write_issue ##1 s_read_back ##0 rd_addr_eff == $past(wr_addr_eff)
    |=> latch_q == $past(masked_wr, 2))
    else $error("read after a write missed the stored word");
  chk_reg_sel_load: assert property (s_reg_sel_load |=> regsel_q == $past(register_source_select_i))
    else $error("register select not captured under its enable");
  chk_reg_sel_hold: assert property (!(read_clock_en_i && register_source_select_en_i) |=> $stable(regsel_q))
    else $error("register select changed without its enable");
  chk_final_sel_hold: assert property (!(read_clock_en_i && final_output_select_en_i) |=> $stable(finsel_q))
    else $error("final select changed without its enable");
  chk_oreg_chain_upper: assert property (s_oreg_chain_load |=> oreg_q[71:36] == $past(chain_hi))
    else $error("output register upper half missed the cascade input");
  chk_first_chain_zero: assert property (order == sdpbr_pkg::SDPBR_ORDER_FIRST ##0 s_oreg_chain_load
    |=> oreg_q[71:36] == 36'h0_0000_0000)
    else $error("bottom block took cascade data from below");
  chk_half_latch_upper: assert property (half_mode ##0 s_read_back |=> latch_q[71:36] == 36'h0_0000_0000)
    else $error("half mode read left data in the upper half");
  chk_coll_clear: assert property (coll_clr && !coll |=> !coll_q)
    else $error("collision flag not cleared by software");
  chk_write_addr_hold: assert property (write_clock_en_i && !write_address_hold_n_i
    |=> wr_addr_q == $past(wr_addr_q))
    else $error("write address changed while held");
  chk_read_addr_take: assert property (read_clock_en_i && read_address_hold_n_i
    |=> rd_addr_q == $past(read_address_i))
    else $error("read address not captured");
  chk_chain_out_match: assert property (chain_data_out_o == read_data_o
    && chain_parity_out_o == read_parity_out_o)
    else $error("cascade output differs from the data output");
  chk_oreg_own_final: assert property (finsel_q == 2'b00 && oreg_on |-> final_word == (oreg_q & half_mask))
    else $error("final output did not come from the output register");

endmodule

`default_nettype wire

//--- sim/sdpbr_fabric.sv
`timescale 1ns/1ns
`default_nettype none
// Fabric side of one block: shared clock enable and the direct write data.
module sdpbr_fabric (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [71:0] word_i,
  output logic rd_ce_o,
  output logic wr_ce_o,
  output logic [63:0] wdata_o,
  output logic [7:0] wpar_o
);
  logic [71:0] last_q;
  logic [71:0] last_d;
  assign rd_ce_o = ce_i;
  assign wr_ce_o = ce_i;
  // Idle write data is the inverse of the last word, so a stale copy never passes.
  assign {wpar_o, wdata_o} = wr_i ? word_i : ~last_q;
  always_comb begin
    last_d = wr_i ? word_i : last_q;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      last_q <= 72'h0;
    end else begin
      last_q <= last_d;
    end
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, x) begin compares++; if ((a) !== (x)) begin bad_count++; $display("unexpected at %0t: %h not %h", $time, a, x); end end
module tb;
  localparam logic [71:0] D1 = 72'ha5_1111_2222_3333_4444;
  localparam logic [71:0] D2 = 72'h5a_5555_6666_7777_8888;
  localparam logic [71:0] D3 = 72'h3c_9999_aaaa_bbbb_cccc;
  localparam logic [71:0] C = 72'hc3_dddd_eeee_ffff_0123;
  localparam logic [71:0] LO = 72'h0f_0000_0000_ffff_ffff;
  localparam logic [11:0] CT = sdpbr_pkg::OFS_CTRL;
  localparam logic [11:0] ST = sdpbr_pkg::OFS_STATUS;
  logic clk_i = 1'h0, arst_n_i = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, rce, wce;
  logic ce = 1'h1, rd = 1'h0, rh = 1'h1, out_reg_clock_enable = 1'h0, orst = 1'h0, lrst = 1'h0;
  logic wr = 1'h0, wh = 1'h1, sleep = 1'h0, rsel_en = 1'h0, fsel_en = 1'h0;
  logic [8:0] ra = 9'h000, wa = 9'h000;
  logic [71:0] wword = 72'h0, below = 72'h0;
  logic [1:0] wsel = 2'h0, rsel = 2'h0, fsel = 2'h0;
  logic [63:0] wdat, rdata, cdata;
  logic [7:0] wpar, rpar, cpar;
  int bad_count = 0, compares = 0;
  sdpbr_fabric u_fab (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .wr_i(wr), .word_i(wword),
    .rd_ce_o(rce), .wr_ce_o(wce), .wdata_o(wdat), .wpar_o(wpar));
  sdpbr_block DUT (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .read_clock_en_i(rce), .read_port_enable_i(rd), .read_address_i(ra), .read_address_hold_n_i(rh),
    .out_reg_clock_enable_i(out_reg_clock_enable), .out_reg_reset_i(orst), .out_latch_reset_i(lrst),
    .read_data_o(rdata), .read_parity_out_o(rpar), .write_clock_en_i(wce), .write_port_enable_i(wr),
    .write_address_i(wa), .write_address_hold_n_i(wh), .write_data_i(wdat), .write_parity_in_i(wpar),
    .sleep_i(sleep), .chain_data_in_i(below[63:0]), .chain_parity_in_i(below[71:64]),
    .chain_data_out_o(cdata), .chain_parity_out_o(cpar), .write_source_select_i(wsel),
    .register_source_select_i(rsel), .register_source_select_en_i(rsel_en),
    .final_output_select_i(fsel), .final_output_select_en_i(fsel_en));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task summarize();
    if (bad_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [71:0] mix(input logic [71:0] h, input logic [71:0] l);
    return (h & ~LO) | (l & LO);
  endfunction
  task cyc(input logic r, input logic [8:0] a, input logic w, input logic [8:0] b, input logic [71:0] d);
    @(posedge clk_i);
    rd <= r;
    ra <= a;
    wr <= w;
    wa <= b;
    wword <= d;
  endtask
  task idle();
    cyc(1'h0, 9'h000, 1'h0, 9'h000, 72'h0);
  endtask
  task rdm(input logic [8:0] a);
    cyc(1'h1, a, 1'h0, 9'h000, 72'h0);
  endtask
  task look(input logic [71:0] x);
    @(negedge clk_i);
    `CHK({rpar, rdata}, x)
    `CHK({cpar, cdata}, x)
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'h1 && n < 8);
    if (pready !== 1'h1) begin
      bad_count++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rdreg(input logic [11:0] a, input logic [31:0] x, input logic ex);
    apb(1'h0, a, 32'h0);
    `CHK(q, x)
    `CHK(e, ex)
  endtask
  task s_reset();
    idle();
    look(sdpbr_pkg::LATCH_SRVAL);
    rdreg(CT, 32'h0, 1'h0);
    apb(1'h1, CT, 32'h25);
    rdreg(CT, 32'h25, 1'h0);
    rdreg(12'h008, 32'h0, 1'h1);
    apb(1'h1, CT, 32'h0);
  endtask
  task s_rw();
    cyc(1'h0, 9'h000, 1'h1, 9'h010, D1);
    cyc(1'h0, 9'h000, 1'h1, 9'h1ff, D2);
    cyc(1'h1, 9'h010, 1'h1, 9'h020, D3);
    rdm(9'h1ff);
    look(D1);
    rdm(9'h020);
    look(D2);
    idle();
    look(D3);
  endtask
  task s_coll();
    for (int m = 0; m < 4; m++) begin
      apb(1'h1, CT, 32'(m));
      cyc(1'h0, 9'h000, 1'h1, 9'h030, D1);
      rdm(9'h1ff);
      cyc(1'h1, 9'h030, 1'h1, 9'h030, D3);
      idle();
      look((m == 1) ? D1 : (m == 2) ? D2 : D3);
      rdm(9'h030);
      idle();
      look(D3);
      rdreg(ST, 32'h1, 1'h0);
      apb(1'h1, ST, 32'h1);
      rdreg(ST, 32'h0, 1'h0);
    end
  endtask
  task s_hold();
    cyc(1'h0, 9'h000, 1'h1, 9'h040, D1);
    cyc(1'h0, 9'h000, 1'h1, 9'h041, D2);
    wh <= 1'h0;
    idle();
    wh <= 1'h1;
    rdm(9'h040);
    rdm(9'h010);
    rh <= 1'h0;
    idle();
    rh <= 1'h1;
    look(D2);
  endtask
  task s_sleep();
    idle();
    sleep <= 1'h1;
    rdreg(ST, 32'h2, 1'h0);
    cyc(1'h1, 9'h010, 1'h1, 9'h040, D3);
    idle();
    sleep <= 1'h0;
    look(D2);
    rdm(9'h040);
    idle();
    look(D2);
    rdm(9'h010);
    lrst <= 1'h1;
    idle();
    lrst <= 1'h0;
    look(sdpbr_pkg::LATCH_SRVAL);
    cyc(1'h1, 9'h040, 1'h0, 9'h000, 72'h0);
    ce <= 1'h0;
    idle();
    ce <= 1'h1;
    look(sdpbr_pkg::LATCH_SRVAL);
  endtask
  task s_oreg();
    apb(1'h1, CT, 32'h4);
    rdm(9'h010);
    out_reg_clock_enable <= 1'h1;
    idle();
    look(sdpbr_pkg::OREG_SRVAL);
    idle();
    look(D1);
    rdm(9'h040);
    out_reg_clock_enable <= 1'h0;
    idle();
    idle();
    look(D1);
    idle();
    out_reg_clock_enable <= 1'h1;
    idle();
    look(D2);
    idle();
    orst <= 1'h1;
    idle();
    orst <= 1'h0;
    look(sdpbr_pkg::OREG_SRVAL);
    rdreg(ST, 32'h4, 1'h0);
  endtask
  task s_casc();
    apb(1'h1, CT, 32'h0);
    idle();
    below <= C;
    fsel <= 2'h3;
    fsel_en <= 1'h1;
    idle();
    fsel <= 2'h0;
    fsel_en <= 1'h0;
    look(C);
    cyc(1'h0, 9'h000, 1'h1, 9'h050, D1);
    wsel <= 2'h1;
    idle();
    wsel <= 2'h0;
    look(C);
    idle();
    fsel_en <= 1'h1;
    rdm(9'h050);
    fsel_en <= 1'h0;
    idle();
    look(mix(D1, C));
    apb(1'h1, CT, 32'h4);
    idle();
    below <= D3;
    rsel <= 2'h2;
    rsel_en <= 1'h1;
    idle();
    rsel_en <= 1'h0;
    idle();
    look(mix(D3, C));
    apb(1'h1, CT, 32'hc);
    idle();
    look(C & LO);
  endtask
  task s_half();
    apb(1'h1, CT, 32'h20);
    cyc(1'h0, 9'h000, 1'h1, 9'h060, D3);
    rdm(9'h060);
    idle();
    look(D3 & LO);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'h1;
    s_reset();
    s_rw();
    s_coll();
    s_hold();
    s_sleep();
    s_oreg();
    s_casc();
    s_half();
    summarize();
  end
endmodule
`default_nettype wire
